// ---- pkg/hpp_pkg.sv ----
// Package of constants and carrier types for the hub port power and boot pin block
package hpp_pkg;
    localparam int NUM_PORTS = 2;
    localparam int CLK_HZ = 50_000_000;
    // Serial ROM clock rates selected by the strap
    localparam int ROM_SLOW_HZ = 30_000_000;
    localparam int ROM_FAST_HZ = 60_000_000;
    // Over-current deglitch time in ns and its cycle count
    localparam int OC_FILTER_NS = 100;
    localparam int OC_FILTER_CYC = (OC_FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [3:0] OC_FILTER_CNT = 4'(OC_FILTER_CYC);
    // Cycles after enabling a port before the pin is trusted as a sense input
    localparam int PWR_SETTLE_CYC = 4;
    localparam logic [3:0] PWR_SETTLE_CNT = 4'(PWR_SETTLE_CYC);
    localparam logic STRAP_RESET = 1'b0;
    localparam logic [NUM_PORTS-1:0] PORT_OFF = 2'h0;

    typedef struct packed {
        logic o;
        logic oe;
    } hpp_pin_t;

    typedef struct packed {
        logic req;
        logic i2c_mode;
        logic power_down;
        logic rom_clk;
        logic i2c_scl_oe;
    } hpp_rom_ctl_t;
endpackage

// ---- rtl/hpp_port_ctl.sv ----
// One downstream port power enable pin with over-current sense
module hpp_port_ctl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic power_on,
    input wire logic pin_i,
    output hpp_pkg::hpp_pin_t pin,
    output logic powered,
    output logic oc_event
);
    // ************************************************************
    // Port power state
    // ************************************************************
    logic en_q, en_d;
    logic [3:0] settle_q, settle_d;
    logic [3:0] filt_q, filt_d;
    logic oc_d;
    logic oc_q;

    always_comb begin
        en_d = en_q;
        settle_d = settle_q;
        filt_d = 4'h0;
        oc_d = 1'b0;
        if (!power_on) begin
            en_d = 1'b0;
            settle_d = 4'h0;
        end else if (!en_q) begin
            en_d = 1'b1;
            settle_d = 4'h0;
        end else if (settle_q != hpp_pkg::PWR_SETTLE_CNT) begin
            settle_d = settle_q + 4'h1;
        end else if (!pin_i) begin
            // Switch pulls the pin low on fault
            filt_d = filt_q + 4'h1;
            if (filt_d == hpp_pkg::OC_FILTER_CNT) begin
                en_d = 1'b0;
                oc_d = 1'b1;
                filt_d = 4'h0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            en_q <= 1'b0;
            settle_q <= 4'h0;
            filt_q <= 4'h0;
            oc_q <= 1'b0;
        end else begin
            en_q <= en_d;
            settle_q <= settle_d;
            filt_q <= filt_d;
            oc_q <= oc_d;
        end
    end

    // Open drain: low holds the switch off, released lets the pull-up enable it
    assign pin.o = 1'b0;
    assign pin.oe = !en_q;
    assign powered = en_q;
    assign oc_event = oc_q;
endmodule

// ---- rtl/hpp_pins.sv ----
// Top of the hub port power, upstream connect and boot ROM pin logic
module hpp_pins (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic [1:0] PORT_POWER_ON,
    input wire logic [1:0] PORT_POWER_CTL_I,
    output logic [1:0] PORT_POWER_CTL_O,
    output logic [1:0] PORT_POWER_CTL_OE,
    output logic [1:0] PORT_POWERED,
    output logic [1:0] PORT_OC_STATUS,
    input wire logic [1:0] PORT_OC_CLEAR,
    input wire logic UPSTREAM_POWER_DETECT,
    output logic UPSTREAM_PULLUP_EN,
    input wire logic ROM_ENABLE,
    input wire hpp_pkg::hpp_rom_ctl_t ROM_CTL,
    input wire logic ROM_SEL,
    output logic ROM_CE_N,
    output logic ROM_CLK_O,
    output logic ROM_CLK_OE,
    input wire logic ROM_DO_I,
    output logic ROM_DO_PULLDOWN,
    output logic ROM_SPEED_FAST,
    output logic ROM_SPEED_VALID
);
    // ************************************************************
    // Pin helpers
    // ************************************************************
    // Pin driven to a level
    function automatic hpp_pkg::hpp_pin_t pin_drive(
        input logic level
    );
        hpp_pkg::hpp_pin_t res;
        res.o = level;
        res.oe = 1'b1;
        return res;
    endfunction

    // Open-drain pin that only ever pulls low
    function automatic hpp_pkg::hpp_pin_t pin_pull_low(
        input logic pull
    );
        hpp_pkg::hpp_pin_t res;
        res.o = 1'b0;
        res.oe = pull;
        return res;
    endfunction

    // Sticky flags, a same-cycle event beats the clear
    function automatic logic [1:0] flag_next(
        input logic [1:0] flag,
        input logic [1:0] clear,
        input logic [1:0] hit
    );
        return (flag & ~clear) | hit;
    endfunction

    // ************************************************************
    // Downstream ports
    // ************************************************************
    hpp_pkg::hpp_pin_t pin [2];
    logic [1:0] oc_evt;

    for (genvar p = 0; p < hpp_pkg::NUM_PORTS; p++) begin : g_port
        hpp_port_ctl u_port (
            .clk(CORE_CLK),
            .rst_n(RESET_N),
            .power_on(PORT_POWER_ON[p]),
            .pin_i(PORT_POWER_CTL_I[p]),
            .pin(pin[p]),
            .powered(PORT_POWERED[p]),
            .oc_event(oc_evt[p])
        );
        assign PORT_POWER_CTL_O[p] = pin[p].o;
        assign PORT_POWER_CTL_OE[p] = pin[p].oe;
    end

    // ************************************************************
    // Over-current flags
    // ************************************************************
    logic [1:0] oc_q;
    logic [1:0] oc_d;

    always_comb begin
        oc_d = flag_next(oc_q, PORT_OC_CLEAR, oc_evt);
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            oc_q <= hpp_pkg::PORT_OFF;
        end else begin
            oc_q <= oc_d;
        end
    end

    assign PORT_OC_STATUS = oc_q;

    // ************************************************************
    // Upstream connect
    // ************************************************************
    logic pu_q;
    logic pu_d;

    always_comb begin
        pu_d = UPSTREAM_POWER_DETECT;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            pu_q <= 1'b0;
        end else begin
            pu_q <= pu_d;
        end
    end

    // Falls with bus power at once, rises one cycle after it
    assign UPSTREAM_PULLUP_EN = pu_q & UPSTREAM_POWER_DETECT;

    // ************************************************************
    // Speed strap
    // ************************************************************
    logic strap_q;
    logic strap_d;
    logic strap_v_q;
    logic strap_v_d;

    always_comb begin
        strap_d = strap_q;
        strap_v_d = 1'b1;
        if (!strap_v_q) begin
            strap_d = ROM_DO_I;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            strap_q <= hpp_pkg::STRAP_RESET;
            strap_v_q <= 1'b0;
        end else begin
            strap_q <= strap_d;
            strap_v_q <= strap_v_d;
        end
    end

    assign ROM_SPEED_FAST = strap_q;
    assign ROM_SPEED_VALID = strap_v_q;
    assign ROM_DO_PULLDOWN = !strap_v_q;

    // ************************************************************
    // Serial ROM pins
    // ************************************************************
    typedef enum logic [1:0] {
        ROM_IDLE,
        ROM_OFF,
        ROM_EEPROM,
        ROM_ACCESS
    } hpp_rom_mode_t;

    // Priority: power-down, then EEPROM clock, then ROM access
    function automatic hpp_rom_mode_t rom_mode(
        input logic enable,
        input hpp_pkg::hpp_rom_ctl_t ctl
    );
        hpp_rom_mode_t mode;
        mode = ROM_IDLE;
        if (enable && ctl.power_down) begin
            mode = ROM_OFF;
        end else if (ctl.i2c_mode) begin
            mode = ROM_EEPROM;
        end else if (enable && ctl.req) begin
            mode = ROM_ACCESS;
        end
        return mode;
    endfunction

    logic ce_n_q;
    logic ce_n_d;
    hpp_pkg::hpp_pin_t rom_clk_q;
    hpp_pkg::hpp_pin_t rom_clk_d;

    always_comb begin
        ce_n_d = 1'b1;
        rom_clk_d = pin_drive(1'b0);
        unique case (rom_mode(ROM_ENABLE, ROM_CTL))
            ROM_IDLE: begin
                ce_n_d = 1'b1;
                rom_clk_d = pin_drive(1'b0);
            end
            ROM_OFF: begin
                ce_n_d = 1'b1;
                rom_clk_d = pin_drive(1'b0);
            end
            ROM_EEPROM: begin
                rom_clk_d = pin_pull_low(ROM_CTL.i2c_scl_oe);
            end
            ROM_ACCESS: begin
                ce_n_d = !ROM_SEL;
                rom_clk_d = pin_drive(ROM_CTL.rom_clk);
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            ce_n_q <= 1'b1;
            rom_clk_q <= pin_drive(1'b0);
        end else begin
            ce_n_q <= ce_n_d;
            rom_clk_q <= rom_clk_d;
        end
    end

    assign ROM_CE_N = ce_n_q;
    assign ROM_CLK_O = rom_clk_q.o;
    assign ROM_CLK_OE = rom_clk_q.oe;
endmodule

// ---- dv/hpp_asserts.sv ----
// Checker for the hub port power and boot pin block
module hpp_asserts (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic [1:0] PORT_POWER_ON,
    input wire logic [1:0] PORT_POWER_CTL_I,
    input wire logic [1:0] PORT_POWER_CTL_OE,
    input wire logic [1:0] PORT_OC_STATUS,
    input wire logic UPSTREAM_POWER_DETECT,
    input wire logic UPSTREAM_PULLUP_EN,
    input wire logic ROM_ENABLE,
    input wire hpp_pkg::hpp_rom_ctl_t ROM_CTL,
    input wire logic ROM_CE_N,
    input wire logic ROM_CLK_O,
    input wire logic ROM_CLK_OE,
    input wire logic ROM_DO_I,
    input wire logic ROM_DO_PULLDOWN,
    input wire logic ROM_SPEED_FAST
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    property p_on; $rose(PORT_POWER_ON[0]) |=> !PORT_POWER_CTL_OE[0]; endproperty
    a_on: assert property (p_on) else $error("port not on");
    property p_oc; !PORT_POWER_CTL_OE[0] [*5] ##1 (!PORT_POWER_CTL_OE[0] && !PORT_POWER_CTL_I[0]) [*5]
        |-> ##[1:3] PORT_POWER_CTL_OE[0]; endproperty
    a_oc: assert property (p_oc) else $error("fault ignored");
    property p_flag; $rose(PORT_POWER_CTL_OE[0]) && $past(PORT_POWER_ON[0]) |=> PORT_OC_STATUS[0]; endproperty
    a_flag: assert property (p_flag) else $error("flag not set");
    property p_pull; UPSTREAM_POWER_DETECT [*2] |-> UPSTREAM_PULLUP_EN; endproperty
    a_pull: assert property (p_pull) else $error("no pullup");
    property p_ce; ROM_ENABLE && ROM_CTL.power_down |=> ROM_CE_N; endproperty
    a_ce: assert property (p_ce) else $error("select low");
    property p_i2c; ROM_CTL.i2c_mode && !(ROM_ENABLE && ROM_CTL.power_down)
        |=> !ROM_CLK_O && ROM_CLK_OE == $past(ROM_CTL.i2c_scl_oe); endproperty
    a_i2c: assert property (p_i2c) else $error("bad i2c clock");
    property p_rclk; disable iff (1'h0) !RESET_N [*2] |-> !ROM_CLK_O && ROM_CLK_OE && ROM_DO_PULLDOWN; endproperty
    a_rclk: assert property (p_rclk) else $error("bad reset pins");
    property p_strap; disable iff (1'h0) !RESET_N ##1 RESET_N
        |=> !ROM_DO_PULLDOWN && ROM_SPEED_FAST == $past(ROM_DO_I); endproperty
    a_strap: assert property (p_strap) else $error("bad strap");
    property p_nopull; !UPSTREAM_POWER_DETECT |-> !UPSTREAM_PULLUP_EN; endproperty
    a_nopull: assert property (p_nopull) else $error("pullup without power");
    property p_rom; ROM_ENABLE && ROM_CTL.req && !ROM_CTL.i2c_mode && !ROM_CTL.power_down
        |=> ROM_CLK_OE && ROM_CLK_O == $past(ROM_CTL.rom_clk); endproperty
    a_rom: assert property (p_rom) else $error("bad rom clock");
    c_oc: cover property (PORT_OC_STATUS[0]);
    c_fast: cover property (ROM_SPEED_FAST);
    c_i2c: cover property (ROM_CTL.i2c_mode && ROM_CLK_OE);
endmodule
bind hpp_pins hpp_asserts i_hpp_asserts (.*);

// ---- dv/hpp_switch.sv ----
// Model of the port power switches and the speed strap resistor
module hpp_switch (
    input wire logic [1:0] enable_n,
    input wire logic [1:0] fault,
    input wire logic strap,
    input wire logic pull_down_on,
    output logic [1:0] sense,
    output logic rom_do
);
    // Pulled-up line, low when held off or when the switch trips
    assign sense = ~(enable_n | fault);
    // Strap seen only while the pull-down is on, inverted once it is released
    assign rom_do = pull_down_on ? strap : ~strap;
endmodule

// ---- dv/hpp_pins_bench.sv ----
// Self-checking bench for the hub port power and boot pin block
module hpp_pins_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic CORE_CLK = 1'h0, RESET_N = 1'h0, UPSTREAM_POWER_DETECT = 1'h0, ROM_ENABLE = 1'h0, ROM_SEL = 1'h0;
    logic ROM_DO_I, UPSTREAM_PULLUP_EN, ROM_CE_N, ROM_CLK_O, ROM_CLK_OE, ROM_DO_PULLDOWN, strap = 1'h0;
    logic ROM_SPEED_FAST, ROM_SPEED_VALID;
    logic [1:0] PORT_POWER_ON = 2'h0, PORT_OC_CLEAR = 2'h0, fault = 2'h0, PORT_POWER_CTL_I;
    logic [1:0] PORT_POWER_CTL_O, PORT_POWER_CTL_OE, PORT_POWERED, PORT_OC_STATUS;
    hpp_pkg::hpp_rom_ctl_t ROM_CTL = 5'h00;
    logic [31:0] seed = 32'hA7C5, r;
    int fail_count = 0, tests_run = 0;
    always #10 CORE_CLK = ~CORE_CLK;
    hpp_pins i_hpp_pins (.*);
    hpp_switch i_hpp_switch (.enable_n(PORT_POWER_CTL_OE), .fault(fault), .strap(strap),
        .pull_down_on(ROM_DO_PULLDOWN), .sense(PORT_POWER_CTL_I), .rom_do(ROM_DO_I));
    function automatic logic [7:0] exp_rom(input logic [7:0] v);
        if (v[6] && v[2]) return 8'h05;
        if (v[3]) return {6'h01, 1'h0, v[0]};
        if (v[6] && v[4]) return {5'h00, !v[5], v[1], 1'h1};
        return 8'h05;
    endfunction
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (fail_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic do_reset(input logic s);
        strap = s;
        RESET_N = 1'h0;
        repeat (2) @(negedge CORE_CLK);
        check({ROM_CLK_O, ROM_CLK_OE, ROM_DO_PULLDOWN}, 8'h03);
        RESET_N = 1'h1;
        repeat (2) @(negedge CORE_CLK);
        check({ROM_SPEED_VALID, ROM_SPEED_FAST, ROM_DO_PULLDOWN}, {5'h00, 1'h1, s, 1'h0});
    endtask
    initial begin
        do_reset(1'h1);
        PORT_POWER_ON = 2'h3;
        repeat (8) @(negedge CORE_CLK);
        check(PORT_POWER_CTL_OE, 8'h00);
        fault = 2'h1;
        for (int i = 0; i < 20 && PORT_POWER_CTL_OE[0] !== 1'h1; i++) @(negedge CORE_CLK);
        if (PORT_POWER_CTL_OE[0] !== 1'h1) begin
            fail_count++;
            complete_run();
        end
        PORT_POWER_ON = 2'h2;
        fault = 2'h0;
        @(negedge CORE_CLK);
        check({PORT_OC_STATUS, PORT_POWER_CTL_OE}, 8'h05);
        PORT_OC_CLEAR = 2'h1;
        @(negedge CORE_CLK);
        PORT_OC_CLEAR = 2'h0;
        check({PORT_OC_STATUS, PORT_POWERED}, 8'h02);
        for (int i = 0; i < 200; i++) begin
            r = rnd();
            {UPSTREAM_POWER_DETECT, ROM_ENABLE, ROM_SEL, ROM_CTL} = r[7:0];
            @(negedge CORE_CLK);
            check(UPSTREAM_PULLUP_EN, r[7]);
            if (r[6] && r[2]) check({ROM_CE_N, ROM_CLK_O, ROM_CLK_OE}, exp_rom(r[7:0]));
            else if (r[3]) check({ROM_CE_N, ROM_CLK_O, ROM_CLK_OE}, exp_rom(r[7:0]));
            else check({ROM_CE_N, ROM_CLK_O, ROM_CLK_OE}, exp_rom(r[7:0]));
        end
        do_reset(1'h0);
        complete_run();
    end
endmodule
